// ===== hw/duty_mon_pkg.sv
// Function
// - measure the asserted fraction of a programmable window as 8 bits, lsb = 1/256
// - window length comes from software; each window end loads the latest duty value
// - each window end but the first after reset or wake sets smoothed to (old smoothed + previous latest) / 2
// - a host write to the latest duty value restarts the measurement window
// - result rounded up to the next whole step; zero only if never asserted, else at least 01h
// - result n means fraction in ((n-1)/256, n/256]; 255 covers above 99.2 percent
// - full-throttle flag when the line never deasserted in the whole window
// - 75-100 band at 193 and up unless full; 50-75 band from 129 to below 193
// - 25-50 band 65 to 128, 12.5-25 band 33 to 64, lowest band 1 to 32
// - any-throttling flag when nonzero; user flag when result exceeds user limit
// - in S3 and S4/5 monitoring stops, latest cleared to 00h, smoothed held
// - in S3 and S4/5 regulator overtemp does not drive the throttle line
// - after return to S0 the first result loads latest and smoothed unaveraged
// - regulator overtemp drives the line low within 10 us, released when it ends
// - a control bit lets software disable the regulator-driven throttle
// - a nonzero force pattern drives a pwm pattern onto the throttle line
// - unmasked regulator hot flags and user flag raise alert when alert_en is set; fixed bands excluded
package duty_mon_pkg;

   localparam int DUTY_W = 8;
   localparam logic [7:0] DUTY_ZERO = 8'h00;
   localparam logic [7:0] DUTY_MAX = 8'hFF;
   localparam logic [7:0] BAND75_MIN = 8'hC1;
   localparam logic [7:0] BAND50_MIN = 8'h81;
   localparam logic [7:0] BAND25_MIN = 8'h41;
   localparam logic [7:0] BAND12_MIN = 8'h21;
   localparam logic [7:0] SLOT_LAST = 8'hFF;

   localparam int SLOT_CNT_W = 24;
   localparam int CLK_PERIOD_NS = 10;
   localparam int REGHOT_RESPONSE_NS = 10000;
   // longest time: rounds down
   localparam int REGHOT_RESPONSE_CYC = REGHOT_RESPONSE_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {SLEEP_S0, SLEEP_S3, SLEEP_S45} sleep_state_t;

   typedef struct packed {
      logic full;
      logic band75;
      logic band50;
      logic band25;
      logic band12;
      logic band0;
      logic any;
      logic user;
   } band_flags_t;

   typedef struct packed {
      logic alert_en;
      logic reghot_dis;
   } response_ctrl_t;

endpackage

// ===== hw/force_pulse_gen.sv
`timescale 1ns/1ps
module force_pulse_gen
   import duty_mon_pkg::*;
#(
   parameter int TICK_CYC = 100
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [DUTY_W-1:0] pattern,
   output logic force_low
);

   logic [15:0] tick_reg;
   logic [DUTY_W-1:0] phase_reg;
   logic tick_end;

   assign tick_end = (tick_reg == 16'(TICK_CYC - 1));

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         tick_reg <= 16'h0000;
         phase_reg <= DUTY_ZERO;
      end
      else if (tick_end)
      begin
         tick_reg <= 16'h0000;
         phase_reg <= phase_reg + 8'h01;
      end
      else
      begin
         tick_reg <= tick_reg + 16'h0001;
      end
   end

   // pattern sets the low share of a 256-tick frame; zero releases the line
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         force_low <= 1'b0;
      end
      else
      begin
         force_low <= (pattern != DUTY_ZERO) && (phase_reg < pattern);
      end
   end

endmodule

// ===== hw/throttle_duty_monitor.sv
`timescale 1ns/1ps
module throttle_duty_monitor
   import duty_mon_pkg::*;
#(
   parameter int SLOT_BASE_CYC = 10,
   parameter int NUM_REGHOT = 2,
   parameter int FORCE_TICK_CYC = 100
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic thermal_throttle_line_n_i,
   input wire logic [NUM_REGHOT-1:0] regulator_overtemp_input_n,
   input wire sleep_state_t sleep_state,
   input wire logic [DUTY_W-1:0] duty_window_length,
   input wire logic [DUTY_W-1:0] user_limit,
   input wire logic [DUTY_W-1:0] throttle_force_pattern,
   input wire response_ctrl_t throttle_response_control,
   input wire logic [NUM_REGHOT:0] error_mask,
   input wire logic latest_duty_wr,
   input wire logic [DUTY_W-1:0] latest_duty_wdata,
   output logic [DUTY_W-1:0] latest_duty_value,
   output logic [DUTY_W-1:0] smoothed_duty_value,
   output band_flags_t throttle_band_flags,
   output logic [NUM_REGHOT-1:0] regulator_hot_status,
   output logic thermal_throttle_line_o,
   output logic thermal_throttle_line_oe,
   output logic alert_n
);

   function automatic logic [SLOT_CNT_W-1:0] slot_cycles(input logic [DUTY_W-1:0] len);
      slot_cycles = SLOT_CNT_W'((32'(len) + 32'd1) * 32'(SLOT_BASE_CYC));
   endfunction

   function automatic band_flags_t classify(input logic [DUTY_W-1:0] m,
                                            input logic full,
                                            input logic [DUTY_W-1:0] lim);
      classify.full = full;
      classify.band75 = (m >= BAND75_MIN) && !full;
      classify.band50 = (m >= BAND50_MIN) && (m < BAND75_MIN);
      classify.band25 = (m >= BAND25_MIN) && (m < BAND50_MIN);
      classify.band12 = (m >= BAND12_MIN) && (m < BAND25_MIN);
      classify.band0 = (m != DUTY_ZERO) && (m < BAND12_MIN);
      classify.any = (m != DUTY_ZERO);
      classify.user = (m > lim);
   endfunction

   // pin synchronisers
   logic line_s1_reg;
   logic line_s2_reg;
   logic [NUM_REGHOT-1:0] reghot_s1_reg;
   logic [NUM_REGHOT-1:0] reghot_s2_reg;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         line_s1_reg <= 1'b1;
         line_s2_reg <= 1'b1;
      end
      else
      begin
         line_s1_reg <= thermal_throttle_line_n_i;
         line_s2_reg <= line_s1_reg;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         reghot_s1_reg <= '0;
         reghot_s2_reg <= '0;
      end
      else
      begin
         reghot_s1_reg <= ~regulator_overtemp_input_n;
         reghot_s2_reg <= reghot_s1_reg;
      end
   end

   logic sleeping;
   logic line_low;
   logic [SLOT_CNT_W-1:0] slot_limit;
   logic [SLOT_CNT_W-1:0] win_sub_reg;
   logic [DUTY_W-1:0] win_slot_reg;
   logic [SLOT_CNT_W-1:0] low_sub_reg;
   logic [DUTY_W-1:0] meas_reg;
   logic seen_high_reg;
   logic any_low_reg;
   logic first_reg;
   logic window_end;
   logic restart;
   logic meas_inc;
   logic [DUTY_W-1:0] meas_final;
   logic seen_high_final;
   logic [DUTY_W-1:0] avg_next;

   assign sleeping = (sleep_state != SLEEP_S0);
   assign line_low = !line_s2_reg;
   assign slot_limit = slot_cycles(duty_window_length);
   assign restart = latest_duty_wr || sleeping;
   // >= guards against the length shrinking mid-window
   assign window_end = (win_slot_reg == SLOT_LAST)
                       && (win_sub_reg >= slot_limit - 24'h000001);
   // a low cycle landing at the start of a slot opens one more step: ceiling
   assign meas_inc = line_low && (low_sub_reg == '0) && (meas_reg != DUTY_MAX);
   assign meas_final = meas_reg + {7'h00, meas_inc};
   assign seen_high_final = seen_high_reg || !line_low;
   assign avg_next = DUTY_W'(({1'b0, smoothed_duty_value}
                              + {1'b0, latest_duty_value}) >> 1);

   // window position: 256 slots of slot_limit cycles each
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || restart || window_end)
      begin
         win_sub_reg <= '0;
         win_slot_reg <= DUTY_ZERO;
      end
      else if (win_sub_reg >= slot_limit - 24'h000001)
      begin
         win_sub_reg <= '0;
         win_slot_reg <= win_slot_reg + 8'h01;
      end
      else
      begin
         win_sub_reg <= win_sub_reg + 24'h000001;
      end
   end

   // low-time accumulator, counted in slots rounded up
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || restart || window_end)
      begin
         low_sub_reg <= '0;
         meas_reg <= DUTY_ZERO;
         seen_high_reg <= 1'b0;
         any_low_reg <= 1'b0;
      end
      else
      begin
         if (line_low)
         begin
            if (low_sub_reg >= slot_limit - 24'h000001)
            begin
               low_sub_reg <= '0;
            end
            else
            begin
               low_sub_reg <= low_sub_reg + 24'h000001;
            end
            any_low_reg <= 1'b1;
         end
         meas_reg <= meas_final;
         seen_high_reg <= seen_high_final;
      end
   end

   // first result after wake or reset is loaded unaveraged
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || sleeping)
      begin
         first_reg <= 1'b1;
      end
      else if (window_end && !latest_duty_wr)
      begin
         first_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         latest_duty_value <= DUTY_ZERO;
      end
      else if (sleeping)
      begin
         latest_duty_value <= DUTY_ZERO;
      end
      else if (latest_duty_wr)
      begin
         latest_duty_value <= latest_duty_wdata;
      end
      else if (window_end)
      begin
         latest_duty_value <= meas_final;
      end
   end

   // smoothed value holds through sleep
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         smoothed_duty_value <= DUTY_ZERO;
      end
      else if (window_end && !restart)
      begin
         if (first_reg)
         begin
            smoothed_duty_value <= meas_final;
         end
         else
         begin
            smoothed_duty_value <= avg_next;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         throttle_band_flags <= '0;
      end
      else if (window_end && !restart)
      begin
         throttle_band_flags <= classify(meas_final, !seen_high_final, user_limit);
      end
   end

   // line drive: regulator overtemp or force pattern
   logic force_low;
   logic reghot_drive;

   force_pulse_gen #(
      .TICK_CYC(FORCE_TICK_CYC)
   ) force_pulse_gen_i (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pattern(throttle_force_pattern),
      .force_low(force_low)
   );

   assign reghot_drive = (|reghot_s2_reg) && !sleeping
                         && !throttle_response_control.reghot_dis;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         thermal_throttle_line_o <= 1'b0;
         thermal_throttle_line_oe <= 1'b0;
      end
      else
      begin
         thermal_throttle_line_o <= 1'b0;
         thermal_throttle_line_oe <= reghot_drive || force_low;
      end
   end

   // status follows the inputs; alert is level, cleared when causes go away
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         regulator_hot_status <= '0;
         alert_n <= 1'b1;
      end
      else
      begin
         regulator_hot_status <= reghot_s2_reg;
         alert_n <= !(throttle_response_control.alert_en
                      && |({regulator_hot_status, throttle_band_flags.user}
                           & ~error_mask));
      end
   end

   // checks
   logic reghot_raw;
   assign reghot_raw = |(~regulator_overtemp_input_n);

   chk_latest_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
      window_end && !restart |=> latest_duty_value == $past(meas_final))
      else $error("latest duty not loaded at window end");

   chk_smooth_avg: assert property (@(posedge clk_sys) disable iff (!rst_n)
      window_end && !restart && !first_reg |=> smoothed_duty_value == $past(avg_next)
      && (smoothed_duty_value >= $past(smoothed_duty_value)
          || smoothed_duty_value >= $past(latest_duty_value))
      && (smoothed_duty_value <= $past(smoothed_duty_value)
          || smoothed_duty_value <= $past(latest_duty_value)))
      else $error("smoothed duty not averaged from previous latest");

   chk_write_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
      latest_duty_wr |=> win_slot_reg == DUTY_ZERO && win_sub_reg == '0
      && meas_reg == DUTY_ZERO)
      else $error("write did not restart the window");

   chk_zero_only_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      window_end && !restart
      |-> (meas_final == DUTY_ZERO) == !(any_low_reg || line_low))
      else $error("zero result does not match idle line");

   chk_full_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      window_end && !restart && !seen_high_final
      |=> throttle_band_flags.full && !throttle_band_flags.band75)
      else $error("full throttle flag wrong");

   chk_band_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_n)
      throttle_band_flags.any
      |-> $onehot({throttle_band_flags.full, throttle_band_flags.band75,
                   throttle_band_flags.band50, throttle_band_flags.band25,
                   throttle_band_flags.band12, throttle_band_flags.band0}))
      else $error("band flags not exclusive");

   chk_sleep_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sleeping ##1 sleeping |-> latest_duty_value == DUTY_ZERO
      && $stable(smoothed_duty_value))
      else $error("sleep did not clear latest or hold smoothed");

   chk_sleep_no_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sleeping && !force_low |=> !thermal_throttle_line_oe)
      else $error("line driven by overtemp in sleep");

   chk_first_unavg: assert property (@(posedge clk_sys) disable iff (!rst_n)
      window_end && !restart && first_reg
      |=> smoothed_duty_value == latest_duty_value)
      else $error("first result after wake was averaged");

   chk_reghot_resp: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reghot_raw && !sleeping && !throttle_response_control.reghot_dis) [*4]
      |-> thermal_throttle_line_oe)
      else $error("overtemp did not drive line in time");

   chk_alert_src: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !alert_n |-> $past(throttle_response_control.alert_en))
      else $error("alert raised while disabled");

   cov_window_done: cover property (@(posedge clk_sys) disable iff (!rst_n)
      window_end && !restart && meas_final != DUTY_ZERO);

   cov_full_window: cover property (@(posedge clk_sys) disable iff (!rst_n)
      window_end && !restart && !seen_high_final);

   cov_wake_first: cover property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(sleeping) ##[1:1000] (window_end && first_reg));

endmodule

// ===== bench/throttle_partner.sv
`timescale 1ns/1ps
module throttle_partner
(
   input wire logic proc_pull,
   input wire logic dut_o,
   input wire logic dut_oe,
   input wire logic [1:0] hot_req,
   output logic line_n,
   output logic [1:0] hot_n
);
   // open-drain line with a board pull-up: a released line reads high, never a held value
   assign line_n = !(proc_pull || (dut_oe && !dut_o));
   assign hot_n = ~hot_req;
endmodule

// ===== bench/throttle_duty_monitor_tb.sv
`timescale 1ns/1ps
module throttle_duty_monitor_tb;
   import duty_mon_pkg::*;
   logic clk_sys, rst_n, proc_pull, line_n, wr, line_o, line_oe, alert_n, first;
   logic [1:0] hot_req, hot_n, hot_status;
   logic [2:0] err_mask;
   logic [7:0] lim, pattern, wdata, latest, smoothed, exp_latest, exp_smooth, win_len;
   sleep_state_t sleep_state;
   response_ctrl_t ctrl;
   band_flags_t flags;
   int error_cnt, checks;

   throttle_partner throttle_partner_i (.proc_pull(proc_pull), .dut_o(line_o),
      .dut_oe(line_oe), .hot_req(hot_req), .line_n(line_n), .hot_n(hot_n));

   throttle_duty_monitor #(.SLOT_BASE_CYC(1), .NUM_REGHOT(2), .FORCE_TICK_CYC(2))
   throttle_duty_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .thermal_throttle_line_n_i(line_n), .regulator_overtemp_input_n(hot_n),
      .sleep_state(sleep_state), .duty_window_length(win_len), .user_limit(lim),
      .throttle_force_pattern(pattern), .throttle_response_control(ctrl),
      .error_mask(err_mask), .latest_duty_wr(wr), .latest_duty_wdata(wdata),
      .latest_duty_value(latest), .smoothed_duty_value(smoothed),
      .throttle_band_flags(flags), .regulator_hot_status(hot_status),
      .thermal_throttle_line_o(line_o), .thermal_throttle_line_oe(line_oe),
      .alert_n(alert_n));

   task end_of_test;
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic band_flags_t exp_flags(input logic [7:0] r, input logic full);
      band_flags_t f;
      f.full = full;
      f.band75 = r >= 8'hC1 && !full;
      f.band50 = r >= 8'h81 && r < 8'hC1;
      f.band25 = r >= 8'h41 && r < 8'h81;
      f.band12 = r >= 8'h21 && r < 8'h41;
      f.band0 = r != 8'h00 && r < 8'h21;
      f.any = r != 8'h00;
      f.user = r > lim;
      return f;
   endfunction

   // window length code 0 with one-cycle slots: 256 cycles, one count per low cycle
   task automatic window(input logic [7:0] len);
      logic [8:0] sum;
      repeat (10) @(negedge clk_sys);
      if (len != 8'h00)
      begin
         proc_pull = 1'b1;
         repeat (len) @(negedge clk_sys);
         proc_pull = 1'b0;
      end
      repeat (246 - int'(len)) @(negedge clk_sys);
      sum = {1'b0, exp_smooth} + {1'b0, exp_latest};
      exp_smooth = first ? len : sum[8:1];
      first = 1'b0;
      exp_latest = len;
      check(latest, exp_latest);
      check(smoothed, exp_smooth);
      check(flags, exp_flags(len, 1'b0));
      check({7'h00, alert_n}, {7'h00, ~(len > lim)});
   endtask

   task automatic write_latest(input logic [7:0] v);
      @(negedge clk_sys);
      wr = 1'b1;
      wdata = v;
      @(negedge clk_sys);
      wr = 1'b0;
      check(latest, v);
      repeat (8) @(negedge clk_sys);
   endtask

   task automatic band_table;
      logic [7:0] tbl [10] = '{8'd1, 8'd33, 8'd32, 8'd65, 8'd64, 8'd129, 8'd128,
         8'd193, 8'd192, 8'd0};
      write_latest(8'h5A);
      foreach (tbl[i])
         window(tbl[i]);
   endtask

   task automatic sleep_hold;
      sleep_state_t st [2] = '{SLEEP_S3, SLEEP_S45};
      foreach (st[i])
      begin
         @(negedge clk_sys);
         sleep_state = st[i];
         hot_req = 2'b01;
         repeat (20) @(negedge clk_sys);
         check(latest, 8'h00);
         check(smoothed, exp_smooth);
         check({7'h00, line_oe}, 8'h00);
         hot_req = 2'b00;
      end
      // let the overtemp synchronisers drain so the wake window starts clean
      repeat (5) @(negedge clk_sys);
      sleep_state = SLEEP_S0;
      first = 1'b1;
      write_latest(8'hA5);
      window(8'd40);
      window(8'd10);
      window(8'd0);
   endtask

   task automatic full_window;
      write_latest(8'h00);
      repeat (10) @(negedge clk_sys);
      proc_pull = 1'b1;
      repeat (502) @(negedge clk_sys);
      check(latest, 8'hFF);
      check(flags, exp_flags(8'hFF, 1'b1));
      proc_pull = 1'b0;
   endtask

   // length code 1 doubles the slot: 512 cycles, and 3 low cycles round up to 2 steps
   task automatic long_window;
      @(negedge clk_sys);
      win_len = 8'h01;
      write_latest(8'h00);
      repeat (10) @(negedge clk_sys);
      proc_pull = 1'b1;
      repeat (3) @(negedge clk_sys);
      proc_pull = 1'b0;
      repeat (300) @(negedge clk_sys);
      check(latest, 8'h00);
      repeat (200) @(negedge clk_sys);
      check(latest, 8'h02);
      check(flags, exp_flags(8'h02, 1'b0));
      win_len = 8'h00;
   endtask

   task automatic overtemp;
      // user flag masked so the alert here can only come from the regulators
      err_mask = 3'b001;
      for (int i = 0; i < 2; i++)
      begin
         @(negedge clk_sys);
         hot_req = i[1:0] + 2'b01;
         repeat (3) @(negedge clk_sys);
         check({7'h00, line_oe}, 8'h01);
         check({7'h00, line_o}, 8'h00);
         check({6'h00, hot_status}, {6'h00, hot_req});
         repeat (2) @(negedge clk_sys);
         check({7'h00, alert_n}, 8'h00);
         hot_req = 2'b00;
         repeat (4) @(negedge clk_sys);
         check({7'h00, line_oe}, 8'h00);
      end
      ctrl.reghot_dis = 1'b1;
      err_mask = 3'b111;
      hot_req = 2'b11;
      repeat (10) @(negedge clk_sys);
      check({7'h00, line_oe}, 8'h00);
      check({7'h00, alert_n}, 8'h01);
      hot_req = 2'b00;
      ctrl.reghot_dis = 1'b0;
      err_mask = 3'b000;
   endtask

   task automatic force_pattern;
      int hi;
      @(negedge clk_sys);
      pattern = 8'h20;
      repeat (512) @(negedge clk_sys);
      hi = 0;
      repeat (512)
      begin
         @(negedge clk_sys);
         hi += int'(line_oe);
      end
      check(8'(hi), 8'h40);
      check(8'(hi >> 8), 8'h00);
      pattern = 8'h00;
      repeat (520) @(negedge clk_sys);
      check({7'h00, line_oe}, 8'h00);
   endtask

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      end_of_test;
   end

   initial
   begin
      rst_n = 1'b0;
      proc_pull = 1'b0;
      hot_req = 2'b00;
      sleep_state = SLEEP_S0;
      lim = 8'h40;
      win_len = 8'h00;
      pattern = 8'h00;
      ctrl = 2'b10;
      err_mask = 3'b000;
      wr = 1'b0;
      wdata = 8'h00;
      first = 1'b1;
      exp_latest = 8'h00;
      exp_smooth = 8'h00;
      error_cnt = 0;
      checks = 0;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      check(latest, 8'h00);
      check(flags, 8'h00);
      check({6'h00, alert_n, line_oe}, 8'h02);
      band_table;
      sleep_hold;
      full_window;
      long_window;
      overtemp;
      force_pattern;
      end_of_test;
   end
endmodule
